// [src/tmr_voter_pkg.sv]
package tmr_voter_pkg;

  localparam int          CHANNELS        = 32;
  localparam int          PATHS           = 3;
  localparam int          BIT_CNT_W       = 5;
  localparam logic [4:0]  LAST_BIT        = 5'h1f;
  localparam logic [31:0] BUS_RESET       = 32'h00000000;

  // axi register byte offsets
  localparam logic [7:0]  OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_VOTED       = 8'h08;
  localparam logic [7:0]  OFS_DISCREP     = 8'h0c;
  localparam logic [7:0]  OFS_IDENT       = 8'h10;
  localparam logic [7:0]  OFS_MONITOR     = 8'h14;

  // control field positions
  localparam int          CTL_ONLINE      = 0;
  localparam int          CTL_TEST_A      = 1;
  localparam int          CTL_TEST_B      = 2;
  localparam int          CTL_TEST_C      = 3;
  localparam int          CTL_PARTNER     = 4;
  localparam logic [4:0]  CONTROL_RESET   = 5'h00;

  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_DECERR     = 2'b11;

  // module identification, value is arbitrary
  localparam logic [15:0] MODULE_IDENT    = 16'h5a3c;

  // online indicator sequence: one second on, one second off
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          BLINK_MS        = 1000;
  localparam int          BLINK_CYCLES    = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [25:0] BLINK_CNT_RESET = 26'h0000000;

  typedef enum logic [3:0]
  {
    LED_OFFLINE = 4'b0001,
    LED_FIRST   = 4'b0010,
    LED_GAP     = 4'b0100,
    LED_STEADY  = 4'b1000
  } led_state_e;

endpackage : tmr_voter_pkg

// [src/tmr_serial_output_voter.sv]
`timescale 1ns/1ns
`default_nettype none

// Contract
// - three serial paths carry 32 channel states
// - shift bit per clock, latch after 32nd
// - close switch when two of three agree
// - channel indicator follows voted switch
// - monitor results return via feedback shifters
// - invert one path alone, report result for path a only
// - each path votes on all 32 channels
// - status and diagnostics over processor bus
// - expose module identification code
// - request switch reported, processors decide
// - link one selects mode 320 or 321
// - link two selects hold or zero
// - link three off hardware-hold forces zero
// - single path: 320 degrades, 321 normal
// - zero turns outputs off, hold keeps
// - health dark on any fault
// - online leds: on, off, then steady
// - offline without partner keeps outputs off
module tmr_serial_output_voter #(
  parameter int BLINK_COUNT = tmr_voter_pkg::BLINK_CYCLES
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [2:0]  serial_data,
  input  wire logic [2:0]  path_ok,
  input  wire logic [31:0] volt_monitor,
  input  wire logic [31:0] curr_monitor,
  input  wire logic [2:0]  feedback_shift,
  input  wire logic        field_supply_ok,
  input  wire logic        request_switch,
  input  wire logic        link_mode_321,
  input  wire logic        link_hold_values,
  input  wire logic        link_hw_hold,
  output logic [31:0]      channel_out,
  output logic [31:0]      channel_led,
  output logic [2:0]       feedback_data,
  output logic [2:0]       online_led,
  output logic             health_led,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [31:0] majority(input logic [31:0] a,
                                           input logic [31:0] b,
                                           input logic [31:0] c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction : majority

  // three-stage pin synchronisers; stage one only feeds stage two
  logic [2:0]  fbs_s1_reg, fbs_s2_reg, fbs_s3_reg;
  logic [2:0]  ok_s1_reg, ok_s2_reg, ok_s3_reg;
  logic [4:0]  misc_s1_reg, misc_s2_reg, misc_s3_reg;
  logic [2:0]  fbs_q, ok_q;
  // serial stream comes from controllers on aclk; a two-sample filter would eat bits
  wire logic [2:0] data_q = serial_data;
  logic [4:0]  misc_q;

  always_ff @(posedge aclk)
  begin
    fbs_s1_reg  <= feedback_shift;
    fbs_s2_reg  <= fbs_s1_reg;
    fbs_s3_reg  <= fbs_s2_reg;
    ok_s1_reg   <= path_ok;
    ok_s2_reg   <= ok_s1_reg;
    ok_s3_reg   <= ok_s2_reg;
    misc_s1_reg <= {field_supply_ok, request_switch, link_mode_321,
                    link_hold_values, link_hw_hold};
    misc_s2_reg <= misc_s1_reg;
    misc_s3_reg <= misc_s2_reg;
  end

  // a change counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fbs_q  <= 3'h0;
      ok_q   <= 3'h0;
      misc_q <= 5'h00;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (fbs_s2_reg[i] == fbs_s3_reg[i])   fbs_q[i]  <= fbs_s2_reg[i];
        if (ok_s2_reg[i] == ok_s3_reg[i])     ok_q[i]   <= ok_s2_reg[i];
      end
      for (int i = 0; i < 5; i++)
        if (misc_s2_reg[i] == misc_s3_reg[i]) misc_q[i] <= misc_s2_reg[i];
    end
  end

  wire logic sup_ok    = misc_q[4];
  wire logic req_sw    = misc_q[3];
  wire logic mode_321  = misc_q[2];
  wire logic hold_link = misc_q[1];
  wire logic hw_hold   = misc_q[0];

  // per-path shifters; each path owns its own register set
  logic [31:0] shift_reg [3];
  logic [4:0]  bit_cnt_reg [3];
  logic [31:0] path_a_channel_bus, path_b_channel_bus, path_c_channel_bus;
  logic [31:0] inject_reg;
  logic [4:0]  control_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int p = 0; p < 3; p++)
      begin
        shift_reg[p]   <= tmr_voter_pkg::BUS_RESET;
        bit_cnt_reg[p] <= 5'h00;
      end
      path_a_channel_bus <= tmr_voter_pkg::BUS_RESET;
      path_b_channel_bus <= tmr_voter_pkg::BUS_RESET;
      path_c_channel_bus <= tmr_voter_pkg::BUS_RESET;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
      begin
        // counter restarts each word, so every scan refreshes the latch
        shift_reg[p]   <= {shift_reg[p][30:0], data_q[p]};
        bit_cnt_reg[p] <= bit_cnt_reg[p] + 5'h01;
      end
      if (bit_cnt_reg[0] == tmr_voter_pkg::LAST_BIT)
        path_a_channel_bus <= {shift_reg[0][30:0], data_q[0]};
      if (bit_cnt_reg[1] == tmr_voter_pkg::LAST_BIT)
        path_b_channel_bus <= {shift_reg[1][30:0], data_q[1]};
      if (bit_cnt_reg[2] == tmr_voter_pkg::LAST_BIT)
        path_c_channel_bus <= {shift_reg[2][30:0], data_q[2]};
    end
  end

  // latent test: one path alone inverts its bus
  logic [2:0] test_sel;
  assign test_sel = control_reg[3:1];
  logic [31:0] eff_a, eff_b, eff_c, voted;
  assign eff_a = test_sel[0] ? ~path_a_channel_bus : path_a_channel_bus;
  assign eff_b = test_sel[1] ? ~path_b_channel_bus : path_b_channel_bus;
  assign eff_c = test_sel[2] ? ~path_c_channel_bus : path_c_channel_bus;
  assign voted = majority(eff_a, eff_b, eff_c);

  // degradation policy
  logic [1:0] ok_count;
  logic       hold_policy, single_path, go_zero, offline_kill;
  assign ok_count     = {1'b0, ok_q[0]} + {1'b0, ok_q[1]} + {1'b0, ok_q[2]};
  assign single_path  = (ok_count <= 2'd1);
  assign hold_policy  = hold_link & hw_hold;
  assign go_zero      = single_path & !mode_321 & !hold_policy;
  assign offline_kill = !control_reg[tmr_voter_pkg::CTL_ONLINE]
                        & !control_reg[tmr_voter_pkg::CTL_PARTNER];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_out <= tmr_voter_pkg::BUS_RESET;
      channel_led <= tmr_voter_pkg::BUS_RESET;
    end
    else if (go_zero || offline_kill)
    begin
      channel_out <= tmr_voter_pkg::BUS_RESET;
      channel_led <= tmr_voter_pkg::BUS_RESET;
    end
    else if (!(single_path && !mode_321))
    begin
      channel_out <= voted;
      channel_led <= voted;
    end
    // else hold: last valid states remain
  end

  // discrepancy per path against majority
  logic [2:0] discrep_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      discrep_reg <= 3'h0;
    else
      discrep_reg <= {|(path_c_channel_bus ^ voted),
                      |(path_b_channel_bus ^ voted),
                      |(path_a_channel_bus ^ voted)};
  end

  // monitor feedback shift registers, one per path
  logic [31:0] fb_shift_reg [3];
  logic [31:0] mon_word;
  logic        lfd_fail_reg;
  assign mon_word = volt_monitor & curr_monitor;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int p = 0; p < 3; p++)
        fb_shift_reg[p] <= tmr_voter_pkg::BUS_RESET;
      feedback_data <= 3'h0;
      lfd_fail_reg  <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
      begin
        if (bit_cnt_reg[p] == tmr_voter_pkg::LAST_BIT)
          fb_shift_reg[p] <= mon_word;
        else
          fb_shift_reg[p] <= {fb_shift_reg[p][30:0], fbs_q[p]};
        feedback_data[p] <= fb_shift_reg[p][31];
      end
      // latent check: confirmed state must match the command
      lfd_fail_reg <= (volt_monitor != channel_out);
    end
  end

  // health indicator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      health_led <= 1'b0;
    else
      health_led <= (&ok_q) & sup_ok & !lfd_fail_reg & !(|discrep_reg)
                    & !(|(curr_monitor & ~volt_monitor));
  end

  // online indicator sequence
  tmr_voter_pkg::led_state_e led_state;
  logic [25:0] blink_cnt_reg;
  logic        online_q_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_state     <= tmr_voter_pkg::LED_OFFLINE;
      blink_cnt_reg <= tmr_voter_pkg::BLINK_CNT_RESET;
      online_q_reg  <= 1'b0;
      online_led    <= 3'h0;
    end
    else
    begin
      online_q_reg <= control_reg[tmr_voter_pkg::CTL_ONLINE];
      case (led_state)
        tmr_voter_pkg::LED_OFFLINE:
          if (control_reg[tmr_voter_pkg::CTL_ONLINE] && !online_q_reg)
          begin
            led_state     <= tmr_voter_pkg::LED_FIRST;
            blink_cnt_reg <= tmr_voter_pkg::BLINK_CNT_RESET;
          end
        tmr_voter_pkg::LED_FIRST, tmr_voter_pkg::LED_GAP:
          if (blink_cnt_reg == 26'(BLINK_COUNT - 1))
          begin
            blink_cnt_reg <= tmr_voter_pkg::BLINK_CNT_RESET;
            led_state     <= (led_state == tmr_voter_pkg::LED_FIRST) ?
                             tmr_voter_pkg::LED_GAP : tmr_voter_pkg::LED_STEADY;
          end
          else
            blink_cnt_reg <= blink_cnt_reg + 26'h0000001;
        tmr_voter_pkg::LED_STEADY: ;
        default: led_state <= tmr_voter_pkg::LED_OFFLINE;
      endcase
      if (!control_reg[tmr_voter_pkg::CTL_ONLINE])
        led_state <= tmr_voter_pkg::LED_OFFLINE;
      online_led <= (led_state == tmr_voter_pkg::LED_FIRST ||
                     led_state == tmr_voter_pkg::LED_STEADY) ? 3'h7 : 3'h0;
    end
  end

  // axi4-lite slave; request switch is a sticky bit
  logic        aw_held, w_held;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        req_sticky_reg, req_q_reg, req_clr;
  assign req_clr = aw_held && w_held && !s_axi_bvalid
                   && aw_addr_reg == tmr_voter_pkg::OFS_STATUS
                   && w_strb_reg[0] && w_data_reg[8];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tmr_voter_pkg::RESP_OKAY;
      control_reg   <= tmr_voter_pkg::CONTROL_RESET;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= tmr_voter_pkg::RESP_OKAY;
        if (aw_addr_reg == tmr_voter_pkg::OFS_CONTROL)
        begin
          // one test path at a time, and only when healthy
          if (w_strb_reg[0] && (w_data_reg[3:1] == 3'h0 || health_led)
              && $countones(w_data_reg[3:1]) <= 1)
            control_reg <= w_data_reg[4:0];
        end
        else if (aw_addr_reg != tmr_voter_pkg::OFS_STATUS)
          s_axi_bresp <= tmr_voter_pkg::RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // switch press edge; set wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_q_reg      <= 1'b0;
      req_sticky_reg <= 1'b0;
    end
    else
    begin
      req_q_reg <= req_sw;
      if (req_sw && !req_q_reg)
        req_sticky_reg <= 1'b1;
      else if (req_clr)
        req_sticky_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= tmr_voter_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= tmr_voter_pkg::RESP_OKAY;
        case (s_axi_araddr)
          tmr_voter_pkg::OFS_CONTROL: s_axi_rdata <= {27'h0, control_reg};
          tmr_voter_pkg::OFS_STATUS:
            s_axi_rdata <= {19'h0, req_sticky_reg, go_zero, lfd_fail_reg,
                            health_led, sup_ok, mode_321, hold_policy,
                            ok_q, discrep_reg};
          tmr_voter_pkg::OFS_VOTED:   s_axi_rdata <= channel_out;
          // uses the tested view of path a, so only an inversion test of path a shows up here
          tmr_voter_pkg::OFS_DISCREP: s_axi_rdata <= voted ^ eff_a;
          tmr_voter_pkg::OFS_IDENT:
            s_axi_rdata <= {16'h0, tmr_voter_pkg::MODULE_IDENT};
          tmr_voter_pkg::OFS_MONITOR: s_axi_rdata <= mon_word;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= tmr_voter_pkg::RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  vote_two_of_three_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!go_zero && !offline_kill && !single_path) |=> channel_out == $past(voted))
    else $error("voted output wrong");
  led_follows_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    channel_led == channel_out) else $error("led mismatch");
  zero_on_degrade_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go_zero |=> channel_out == 32'h0) else $error("not driven to zero");
  hold_last_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (single_path && !mode_321 && hold_policy && !offline_kill)
    |=> $stable(channel_out)) else $error("hold lost");
  latch_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_cnt_reg[0] == 5'h1f |=> path_a_channel_bus == (($past(shift_reg[0]) << 1)
    | 32'($past(data_q[0])))) else $error("latch wrong");
  offline_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    offline_kill |=> channel_out == 32'h0) else $error("offline energised");
  discrep_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (path_b_channel_bus != voted) |=> discrep_reg[1]) else $error("no flag");
  health_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sup_ok || |discrep_reg) |=> !health_led) else $error("health lit");
  online_blink_a: assert property (@(posedge aclk) disable iff (!aresetn)
    led_state == tmr_voter_pkg::LED_GAP |=> online_led == 3'h0)
    else $error("gap lit");

endmodule : tmr_serial_output_voter

`default_nettype wire

// [tb/path_controllers.sv]
`timescale 1ns/1ns
`default_nettype none

module path_controllers (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] word_a,
  input  wire logic [31:0] word_b,
  input  wire logic [31:0] word_c,
  output logic [2:0]       serial_data
);
  logic [4:0]  bit_idx;
  logic [31:0] frame_a;
  logic [31:0] frame_b;
  logic [31:0] frame_c;

  // phase follows the block's free-running bit counter from reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bit_idx <= 5'h00;
    else
      bit_idx <= bit_idx + 5'h01;
  end

  // new words only at a frame boundary, so every scan resends whole words
  always_ff @(posedge aclk)
  begin
    if (!aresetn || bit_idx == 5'h1f)
    begin
      frame_a <= word_a;
      frame_b <= word_b;
      frame_c <= word_c;
    end
  end

  // one bit per clock on each path, msb first
  assign serial_data = {frame_c[5'h1f - bit_idx], frame_b[5'h1f - bit_idx],
                        frame_a[5'h1f - bit_idx]};
endmodule : path_controllers

`default_nettype wire

// [tb/tmr_serial_output_voter_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module tmr_serial_output_voter_tb;
  localparam int         BLINK    = 8;
  // {mode321, hold, hw, path_ok, 0 normal / 1 hold / 2 zero}
  localparam logic [7:0] ROWS [5] = '{8'h84, 8'h65, 8'h46, 8'h26, 8'h0c};
  logic        aclk, aresetn, field_supply_ok, request_switch, health_led;
  logic        link_mode_321, link_hold_values, link_hw_hold;
  logic [2:0]  serial_data, path_ok, feedback_shift, feedback_data, online_led;
  logic [31:0] volt_monitor, curr_monitor, channel_out, channel_led, wa, wb, wc;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fails, n_compared;

  tmr_serial_output_voter #(.BLINK_COUNT(BLINK)) dut (
    .aclk, .aresetn, .serial_data, .path_ok, .volt_monitor, .curr_monitor, .feedback_shift,
    .field_supply_ok, .request_switch, .link_mode_321, .link_hold_values, .link_hw_hold,
    .channel_out, .channel_led, .feedback_data, .online_led, .health_led,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  path_controllers partner (.aclk, .aresetn, .word_a(wa), .word_b(wb), .word_c(wc), .serial_data);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic conclude();
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(tmr_voter_pkg::RESP_OKAY));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic do_reset(input logic online);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    if (online)
      axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000001);
  endtask : do_reset

  // frame is 32 cycles; 100 covers boundary wait, shift, latch and output register
  task automatic send(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    wa <= a;
    wb <= b;
    wc <= c;
    volt_monitor <= (a & b) | (a & c) | (b & c);
    curr_monitor <= (a & b) | (a & c) | (b & c);
    repeat (100) @(posedge aclk);
  endtask : send

  task automatic t_reset_state();
    chk(channel_out, 32'h00000000);
    axi_rd(tmr_voter_pkg::OFS_IDENT);
    chk(rd_data, {16'h0000, tmr_voter_pkg::MODULE_IDENT});
    axi_rd(8'h20);
    chk(32'(rd_resp), 32'(tmr_voter_pkg::RESP_DECERR));
    chk(rd_data, 32'h00000000);
  endtask : t_reset_state

  task automatic t_online();
    int n;
    logic [2:0] pat;
    axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000001);
    n = 0;
    while (online_led !== 3'b111 && n < 40)
    begin
      @(posedge aclk);
      n++;
    end
    for (int ph = 0; ph < 2; ph++)
    begin
      pat = (ph == 0) ? 3'b111 : 3'b000;
      n = 0;
      while (online_led === pat && n < 40)
      begin
        @(posedge aclk);
        n++;
      end
      chk(n, BLINK);
    end
    repeat (3 * BLINK) @(posedge aclk);
    chk(32'(online_led), 32'h7);
  endtask : t_online

  task automatic t_vote();
    send(32'h80000001, 32'h80000001, 32'h80000001);
    chk(channel_out, 32'h80000001);
    chk(32'(health_led), 32'h1);
    send(32'hffff0000, 32'hff00ff00, 32'hf0f0f0f0);
    chk(channel_out, 32'hfff0f000);
    chk(channel_led, 32'hfff0f000);
    chk(32'(health_led), 32'h0);
    axi_rd(tmr_voter_pkg::OFS_VOTED);
    chk(rd_data, 32'hfff0f000);
    axi_rd(tmr_voter_pkg::OFS_DISCREP);
    chk(rd_data, 32'h000ff000);
    axi_rd(tmr_voter_pkg::OFS_STATUS);
    chk(32'(rd_data[2:0]), 32'h7);
  endtask : t_vote

  task automatic t_health_test();
    do_reset(1'b1);
    send(32'h0000ffff, 32'h0000ffff, 32'h0000ffff);
    axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000007);
    axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000003, 4'he);
    axi_rd(tmr_voter_pkg::OFS_CONTROL);
    chk(rd_data, 32'h00000001);
    axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000003);
    repeat (40) @(posedge aclk);
    chk(channel_out, 32'h0000ffff);
    axi_rd(tmr_voter_pkg::OFS_DISCREP);
    chk(rd_data, 32'hffffffff);
    do_reset(1'b1);
    send(32'h0000ffff, 32'h0000ffff, 32'h0000ffff);
    field_supply_ok <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'(health_led), 32'h0);
    axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000003);
    axi_rd(tmr_voter_pkg::OFS_CONTROL);
    chk(rd_data, 32'h00000001);
    field_supply_ok <= 1'b1;
    do_reset(1'b1);
    send(32'h0000ffff, 32'h0000ffff, 32'h0000ffff);
    volt_monitor <= 32'h00000000;
    repeat (10) @(posedge aclk);
    chk(32'(health_led), 32'h0);
  endtask : t_health_test

  task automatic t_request();
    request_switch <= 1'b1;
    repeat (10) @(posedge aclk);
    request_switch <= 1'b0;
    repeat (10) @(posedge aclk);
    axi_rd(tmr_voter_pkg::OFS_STATUS);
    chk(32'(rd_data[12]), 32'h1);
    axi_rd(tmr_voter_pkg::OFS_CONTROL);
    chk(rd_data, 32'h00000001);
    axi_wr(tmr_voter_pkg::OFS_STATUS, 32'h00000100);
    axi_rd(tmr_voter_pkg::OFS_STATUS);
    chk(32'(rd_data[12]), 32'h0);
    axi_wr(tmr_voter_pkg::OFS_CONTROL, 32'h00000000);
    repeat (10) @(posedge aclk);
    chk(channel_out, 32'h00000000);
  endtask : t_request

  task automatic t_degrade();
    for (int i = 0; i < 5; i++)
    begin
      link_mode_321 <= ROWS[i][7];
      link_hold_values <= ROWS[i][6];
      link_hw_hold <= ROWS[i][5];
      path_ok <= 3'b111;
      do_reset(1'b1);
      send(32'h0000ffff, 32'h0000ffff, 32'h0000ffff);
      path_ok <= ROWS[i][4:2];
      repeat (10) @(posedge aclk);
      send(32'h12345678, 32'h12345678, 32'h12345678);
      chk(channel_out, (ROWS[i][1:0] == 2'd0) ? 32'h12345678 :
                       (ROWS[i][1:0] == 2'd1) ? 32'h0000ffff : 32'h0);
    end
  endtask : t_degrade

  // whole run needs about 2000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude();
  end

  initial
  begin
    fails = 0;
    n_compared = 0;
    aresetn = 1'b0;
    path_ok = 3'b111;
    feedback_shift = 3'b000;
    field_supply_ok = 1'b1;
    request_switch = 1'b0;
    link_mode_321 = 1'b0;
    link_hold_values = 1'b0;
    link_hw_hold = 1'b1;
    wa = 32'h0;
    wb = 32'h0;
    wc = 32'h0;
    volt_monitor = 32'h0;
    curr_monitor = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    s_axi_wdata = 32'h0;
    do_reset(1'b0);
    t_reset_state();
    t_online();
    t_vote();
    t_health_test();
    t_request();
    t_degrade();
    conclude();
  end
endmodule : tmr_serial_output_voter_tb

`default_nettype wire
